// file: logic/swl_master.sv
// single-wire link master: flags, interrupt output, slot generator and transmit fifo
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module swl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign o_in_ready = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem[rd_ptr_r];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule : swl_fifo

////////////////////////////////////////////////////////////////////////////////
module swl_master #(
   parameter int TICK_DIV = swl_pkg::TICK_CYCLES,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire swl_pkg::host_req_t i_host_req,
   output logic [7:0] o_rdata,
   output logic o_tx_ready,
   output logic o_irq_out,
   input wire logic i_dq_in,
   output logic o_dq_out,
   output logic o_dq_oe
);
   // timebase must stay within 1 to 1.25 us at the 40 ns clock
   generate
      if (TICK_DIV * swl_pkg::CLK_PERIOD_NS < 1000 || TICK_DIV * swl_pkg::CLK_PERIOD_NS > 1250) begin : g_bad_div
         $error("timebase divider gives a tick outside 1 to 1.25 us");
      end
   endgenerate

   logic rst_meta_r;
   logic rst_n_r;
   logic [$clog2(TICK_DIV+1)-1:0] div_r;
   logic tick;
   swl_pkg::link_state_t state_r;
   logic [9:0] cnt_r;
   logic [5:0] pcnt_r;
   logic edge_seen_r;
   logic sampled_r;
   logic dq_q_r;
   logic fall;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic [7:0] rx_buf_r;
   logic [2:0] bit_idx_r;
   logic tx_full_r;
   logic [1:0] cmd_r;
   logic [7:0] en_r;
   swl_pkg::event_flags_t flags_r;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic fifo_valid_q_r;
   logic load;
   logic wr_data;
   logic wr_cmd;
   logic rd_flags;
   logic rd_data;
   logic start_reset;
   logic pres_set;
   logic byte_done;
   logic rx_move;
   logic irq_act;

   ////////////////////////////////////////////////////////////////////////////
   // reset release and timebase; the divider restarts when a byte or a bus reset starts so the first tick is a whole one
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   assign tick = (div_r == '0);

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_r <= '0;
      end else if (tick || start_reset || load) begin
         div_r <= ($bits(div_r))'(TICK_DIV - 1);
      end else begin
         div_r <= div_r - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host decode; write takes precedence over a simultaneous read
   assign wr_cmd = i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_COMMAND;
   assign wr_data = i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_DATA;
   assign rd_flags = i_host_req.rd && !i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_EVENT_FLAGS;
   assign rd_data = i_host_req.rd && !i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_DATA;

   swl_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n_r),
      .i_in_valid(wr_data),
      .o_in_ready(o_tx_ready),
      .i_in_data(i_host_req.wdata),
      .o_out_valid(fifo_valid),
      .i_out_ready(load),
      .o_out_data(fifo_data)
   );

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cmd_r <= 2'h0;
      end else if (wr_cmd) begin
         cmd_r[swl_pkg::CMD_BUS_RESET_BIT] <= i_host_req.wdata[swl_pkg::CMD_BUS_RESET_BIT];
         cmd_r[swl_pkg::CMD_SEARCH_BIT] <= i_host_req.wdata[swl_pkg::CMD_SEARCH_BIT]
            & ~i_host_req.wdata[swl_pkg::CMD_BUS_RESET_BIT];
      end else if (pres_set) begin
         cmd_r[swl_pkg::CMD_BUS_RESET_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         en_r <= swl_pkg::EN_RESET;
      end else if (i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_EVENT_ENABLE) begin
         en_r <= i_host_req.wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rdata <= 8'h00;
      end else if (i_host_req.rd && !i_host_req.wr) begin
         unique case (i_host_req.addr)
            swl_pkg::ADDR_COMMAND: o_rdata <= {6'h00, cmd_r};
            swl_pkg::ADDR_DATA: o_rdata <= rx_buf_r;
            swl_pkg::ADDR_EVENT_FLAGS: o_rdata <= flags_r;
            swl_pkg::ADDR_EVENT_ENABLE: o_rdata <= en_r;
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slot generator
   assign fall = dq_q_r & ~i_dq_in;
   assign start_reset = (state_r == swl_pkg::ST_IDLE) && cmd_r[swl_pkg::CMD_BUS_RESET_BIT];
   assign load = (state_r == swl_pkg::ST_IDLE) && !start_reset && !tx_full_r
      && !flags_r.rx_shifter_full && fifo_valid;
   assign pres_set = tick && state_r == swl_pkg::ST_RST_HIGH && cnt_r == swl_pkg::RESET_HIGH_TIME - 1'b1;
   assign byte_done = tick && state_r == swl_pkg::ST_RECOVER && bit_idx_r == 3'h7;
   assign rx_move = flags_r.rx_shifter_full && !flags_r.rx_buffer_full;

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         dq_q_r <= 1'b1;
      end else begin
         dq_q_r <= i_dq_in;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= swl_pkg::ST_IDLE;
         cnt_r <= '0;
      end else if (start_reset) begin
         state_r <= swl_pkg::ST_RST_LOW;
         cnt_r <= '0;
      end else if (load) begin
         state_r <= swl_pkg::ST_SLOT_LOW;
         cnt_r <= '0;
      end else if (tick) begin
         cnt_r <= cnt_r + 1'b1;
         unique case (state_r)
            swl_pkg::ST_IDLE: begin
               cnt_r <= '0;
            end
            swl_pkg::ST_RST_LOW: begin
               if (cnt_r == swl_pkg::RESET_LOW_TIME - 1'b1) begin
                  state_r <= swl_pkg::ST_RST_HIGH;
                  cnt_r <= '0;
               end
            end
            swl_pkg::ST_RST_HIGH: begin
               if (pres_set) begin
                  state_r <= swl_pkg::ST_IDLE;
                  cnt_r <= '0;
               end
            end
            swl_pkg::ST_SLOT_LOW: begin
               if (cnt_r == (tx_sh_r[0] ? swl_pkg::WRITE_ONE_LOW_TIME : swl_pkg::WRITE_ZERO_LOW_TIME) - 1'b1) begin
                  state_r <= swl_pkg::ST_SLOT_HIGH;
               end
            end
            swl_pkg::ST_SLOT_HIGH: begin
               if (cnt_r == swl_pkg::SLOT_TIME - 1'b1) begin
                  state_r <= swl_pkg::ST_RECOVER;
                  cnt_r <= '0;
               end
            end
            swl_pkg::ST_RECOVER: begin
               if (cnt_r == swl_pkg::RECOVERY_TIME - 1'b1) begin
                  state_r <= (bit_idx_r == 3'h7) ? swl_pkg::ST_IDLE : swl_pkg::ST_SLOT_LOW;
                  cnt_r <= '0;
               end
            end
            default: begin
               state_r <= swl_pkg::ST_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // line is only ever pulled low; released means high impedance
   assign o_dq_out = 1'b0;
   assign o_dq_oe = (state_r == swl_pkg::ST_RST_LOW) || (state_r == swl_pkg::ST_SLOT_LOW);

   // presence detection after the reset pulse
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         edge_seen_r <= 1'b0;
         pcnt_r <= '0;
         sampled_r <= 1'b1;
      end else if (state_r != swl_pkg::ST_RST_HIGH) begin
         edge_seen_r <= 1'b0;
         pcnt_r <= '0;
         if (start_reset) begin
            sampled_r <= 1'b1;
         end
      end else if (!edge_seen_r) begin
         if (fall && cnt_r < swl_pkg::PRESENCE_WAIT_TICKS) begin
            edge_seen_r <= 1'b1;
         end
      end else if (tick && pcnt_r != swl_pkg::PRESENCE_SAMPLE_TIME) begin
         pcnt_r <= pcnt_r + 1'b1;
         if (pcnt_r == swl_pkg::PRESENCE_SAMPLE_TIME - 1'b1) begin
            sampled_r <= i_dq_in;
         end
      end
   end

   // bit shifting, lsb first; a write-one slot doubles as a read slot
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         bit_idx_r <= 3'h0;
         tx_full_r <= 1'b0;
      end else if (load) begin
         tx_sh_r <= fifo_data;
         bit_idx_r <= 3'h0;
         tx_full_r <= 1'b1;
      end else if (tick) begin
         // a write-zero slot is still low at the sample point, so it shifts in a zero
         if ((state_r == swl_pkg::ST_SLOT_LOW || state_r == swl_pkg::ST_SLOT_HIGH)
            && cnt_r == swl_pkg::READ_SAMPLE_TIME - 1'b1) begin
            rx_sh_r <= {i_dq_in, rx_sh_r[7:1]};
         end
         if (state_r == swl_pkg::ST_RECOVER && cnt_r == swl_pkg::RECOVERY_TIME - 1'b1) begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            bit_idx_r <= bit_idx_r + 1'b1;
            if (bit_idx_r == 3'h7) begin
               tx_full_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_buf_r <= 8'h00;
      end else if (rx_move) begin
         rx_buf_r <= rx_sh_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: a setting event wins over a clear in the same cycle
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         fifo_valid_q_r <= 1'b0;
      end else begin
         fifo_valid_q_r <= fifo_valid;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         flags_r <= swl_pkg::FLAGS_RESET;
      end else begin
         if (pres_set) begin
            flags_r.presence_done <= 1'b1;
            flags_r.presence_result <= edge_seen_r ? sampled_r : 1'b1;
         end else if (rd_flags) begin
            flags_r.presence_done <= 1'b0;
            flags_r.presence_result <= 1'b0;
         end
         if (fifo_valid_q_r && !fifo_valid) begin
            flags_r.tx_buffer_empty <= 1'b1;
         end else if (rd_flags || wr_data) begin
            flags_r.tx_buffer_empty <= 1'b0;
         end
         if (byte_done) begin
            flags_r.tx_shifter_empty <= 1'b1;
         end else if (rd_flags || load) begin
            flags_r.tx_shifter_empty <= 1'b0;
         end
         if (byte_done) begin
            flags_r.rx_shifter_full <= 1'b1;
         end else if (rx_move) begin
            flags_r.rx_shifter_full <= 1'b0;
         end
         if (rx_move) begin
            flags_r.rx_buffer_full <= 1'b1;
         end else if (rd_data) begin
            flags_r.rx_buffer_full <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt output, inactive high after reset
   assign irq_act = |(flags_r & en_r & swl_pkg::EN_SOURCE_MASK);

   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_irq_out <= 1'b1;
      end else begin
         o_irq_out <= en_r[swl_pkg::EN_POLARITY_BIT] ? irq_act : ~irq_act;
      end
   end
endmodule : swl_master

// file: logic/swl_pkg.sv
// package: register map, flag layout, slot timing for the single-wire link master
package swl_pkg;
   // register indices on the three-bit register select
   localparam logic [2:0] ADDR_COMMAND = 3'h0;
   localparam logic [2:0] ADDR_DATA = 3'h1;
   localparam logic [2:0] ADDR_EVENT_FLAGS = 3'h2;
   localparam logic [2:0] ADDR_EVENT_ENABLE = 3'h3;

   // command register fields
   localparam int CMD_BUS_RESET_BIT = 0;
   localparam int CMD_SEARCH_BIT = 1;

   // interrupt enable register: bit 1 is the output polarity, not an enable
   localparam int EN_POLARITY_BIT = 1;
   localparam logic [7:0] EN_SOURCE_MASK = 8'h3d;
   localparam logic [7:0] EN_RESET = 8'h00;

   // clock and timebase
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

   // slot timing in timebase ticks
   localparam logic [9:0] RESET_LOW_TIME = 10'd500;
   localparam logic [9:0] RESET_HIGH_TIME = 10'd500;
   localparam logic [5:0] PRESENCE_SAMPLE_TIME = 6'd30;
   localparam int PRESENCE_WAIT_US = 60;
   localparam logic [9:0] PRESENCE_WAIT_TICKS = 10'((PRESENCE_WAIT_US * 1000) / TICK_NS);
   localparam logic [9:0] WRITE_ONE_LOW_TIME = 10'd1;
   localparam logic [9:0] WRITE_ZERO_LOW_TIME = 10'd75;
   localparam int READ_SAMPLE_US = 15;
   localparam logic [9:0] READ_SAMPLE_TIME = 10'((READ_SAMPLE_US * 1000 + TICK_NS - 1) / TICK_NS);
   localparam logic [9:0] SLOT_TIME = 10'd80;
   localparam logic [9:0] RECOVERY_TIME = 10'd1;

   // flag register layout, lsb last
   typedef struct packed {
      logic [1:0] unused;
      logic rx_shifter_full;
      logic rx_buffer_full;
      logic tx_shifter_empty;
      logic tx_buffer_empty;
      logic presence_result;
      logic presence_done;
   } event_flags_t;

   localparam event_flags_t FLAGS_RESET = '{unused: 2'h0, rx_shifter_full: 1'b0, rx_buffer_full: 1'b0,
      tx_shifter_empty: 1'b1, tx_buffer_empty: 1'b1, presence_result: 1'b1, presence_done: 1'b0};

   // host access strobes, synchronous to the clock
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RST_LOW = 3'b001,
      ST_RST_HIGH = 3'b010,
      ST_SLOT_LOW = 3'b011,
      ST_SLOT_HIGH = 3'b100,
      ST_RECOVER = 3'b101
   } link_state_t;
endpackage : swl_pkg

// file: test/swl_master_properties.sv
// checker: port-level timing and register properties of the link master
`timescale 1ns/1ps
module swl_master_properties #(
   parameter int TICK_DIV = 25
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire swl_pkg::host_req_t i_host_req,
   input wire logic [7:0] o_rdata,
   input wire logic o_tx_ready,
   input wire logic o_irq_out,
   input wire logic i_dq_in,
   input wire logic o_dq_out,
   input wire logic o_dq_oe
);
   localparam int TD = TICK_DIV;
   logic [15:0] lo_cnt;
   logic [15:0] hi_cnt;
   logic [15:0] per_cnt;
   logic oe_q;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // cycles low, then cycles released and fall-to-fall period, both saturating
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lo_cnt <= 16'h0;
         hi_cnt <= 16'hffff;
         per_cnt <= 16'hffff;
         oe_q <= 1'b0;
      end else begin
         oe_q <= o_dq_oe;
         lo_cnt <= o_dq_oe ? lo_cnt + 16'h1 : 16'h0;
         hi_cnt <= o_dq_oe ? 16'h0 : hi_cnt + 16'(hi_cnt != 16'hffff);
         per_cnt <= (o_dq_oe && !oe_q) ? 16'h1 : per_cnt + 16'(per_cnt != 16'hffff);
      end
   end

   function automatic logic near(input logic [15:0] c, input int n);
      return (int'(c) >= n * TD) && (int'(c) < n * TD + TD);
   endfunction : near

   sequence rd_flags;
      i_host_req.rd && !i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_EVENT_FLAGS;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   a_line_only_low: assert property (o_dq_out == 1'b0)
      else $error("data line driven high");
   a_oe_off_reset: assert property (disable iff (1'b0) !i_rst_n |-> !o_dq_oe)
      else $error("line pulled during reset");
   a_low_time_legal: assert property ($fell(o_dq_oe) |-> near(lo_cnt, 1) || near(lo_cnt, 75) || near(lo_cnt, 500))
      else $error("line low time not a slot length");
   a_gap_released: assert property ($rose(o_dq_oe) |-> hi_cnt >= 16'(TD - 1))
      else $error("no released tick before slot");
   a_slot_period: assert property ($rose(o_dq_oe) |-> per_cnt >= 16'(81 * TD - 2))
      else $error("slot ended early");
   a_irq_idle_reset: assert property ($rose(i_rst_n) |-> o_irq_out == 1'b1)
      else $error("interrupt active after reset");
   a_read_clears: assert property (rd_flags ##1 rd_flags |=> o_rdata[3:0] == 4'h0 && o_rdata[5:4] == $past(o_rdata[5:4]))
      else $error("flag read clear wrong");
   a_irq_polarity: assert property (i_host_req.wr && i_host_req.addr == swl_pkg::ADDR_EVENT_ENABLE
      && (i_host_req.wdata & swl_pkg::EN_SOURCE_MASK) == 8'h0
      |-> ##2 o_irq_out == !$past(i_host_req.wdata[swl_pkg::EN_POLARITY_BIT], 2))
      else $error("masked interrupt level wrong");

   c_reset_pulse: cover property ($fell(o_dq_oe) && near(lo_cnt, 500));
   c_zero_slot: cover property ($fell(o_dq_oe) && near(lo_cnt, 75));
   c_double_read: cover property (rd_flags ##1 rd_flags);
endmodule : swl_master_properties

bind swl_master swl_master_properties #(.TICK_DIV(TICK_DIV)) props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_host_req(i_host_req), .o_rdata(o_rdata), .o_tx_ready(o_tx_ready), .o_irq_out(o_irq_out),
   .i_dq_in(i_dq_in), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));

// file: test/swl_slave.sv
// partner model: one slave on the pulled-up data line
`timescale 1ns/1ps
module swl_slave (
   input wire logic i_dq,
   input wire logic i_present,
   input wire logic [7:0] i_hold_mask,
   output logic o_pull,
   output logic [7:0] o_rx_byte
);
   time t_fall;
   int idx = 0;
   logic bit_v;

   initial begin
      o_pull = 1'b0;
      o_rx_byte = 8'h00;
   end

   // own pulls are never seen as falls: this process is busy while it pulls
   always begin
      @(negedge i_dq);
      t_fall = $time;
      o_pull = (idx < 8) && i_hold_mask[idx[2:0]];
      #30_000 bit_v = i_dq;
      #10_000 o_pull = 1'b0;
      if (i_dq === 1'b0) @(posedge i_dq);
      if ($time - t_fall > 400_000) begin
         idx = 0;
         if (i_present === 1'b1) begin
            #20_000 o_pull = 1'b1;
            #100_000 o_pull = 1'b0;
         end
      end else begin
         o_rx_byte = {bit_v, o_rx_byte[7:1]};
         idx++;
      end
   end
endmodule : swl_slave

// file: test/swl_master_test.sv
// testbench: register rows, bus resets, one byte, fifo refusal, mid-run reset
`timescale 1ns/1ps
module swl_master_test;
   localparam int TD = 25;
   typedef struct packed {
      logic wr;
      logic [2:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
      logic irq;
   } row_t;
   localparam row_t ROWS [8] = '{'{1'b0, 3'h2, 8'h00, 8'h0e, 1'b1}, '{1'b0, 3'h2, 8'h00, 8'h00, 1'b1},
      '{1'b1, 3'h3, 8'h02, 8'h02, 1'b0}, '{1'b1, 3'h3, 8'h3f, 8'h3f, 1'b0}, '{1'b1, 3'h3, 8'h00, 8'h00, 1'b1},
      '{1'b1, 3'h5, 8'h5a, 8'h00, 1'b1}, '{1'b1, 3'h0, 8'h02, 8'h02, 1'b1}, '{1'b1, 3'h0, 8'h00, 8'h00, 1'b1}};
   logic clk = 1'b0;
   logic rst_n = 1'b1;
   swl_pkg::host_req_t req = '0;
   logic [7:0] rdata;
   logic tx_ready;
   logic irq;
   logic dq_out;
   logic dq_oe;
   logic pull;
   logic present = 1'b0;
   logic [7:0] mask = 8'h00;
   logic [7:0] cap;
   logic [7:0] v;
   int err_count = 0;
   int total_checks = 0;
   int n;
   wire dq = !(dq_oe || pull);

   always #20 clk = ~clk;

   swl_master dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_host_req(req), .o_rdata(rdata), .o_tx_ready(tx_ready),
      .o_irq_out(irq), .i_dq_in(dq), .o_dq_out(dq_out), .o_dq_oe(dq_oe));
   swl_slave slave (.i_dq(dq), .i_present(present), .i_hold_mask(mask), .o_pull(pull), .o_rx_byte(cap));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   // tasks enter and leave 1 ns after a rising edge; cyc keeps the request up
   task automatic cyc(input logic w, input logic [2:0] addr, input logic [7:0] data);
      req = '{wr: w, rd: !w, addr: addr, wdata: data};
      @(posedge clk);
      #1;
   endtask : cyc

   task automatic idle;
      req = '0;
      @(posedge clk);
      #1;
   endtask : idle

   task automatic reg_rd(input logic [2:0] addr, output logic [7:0] data);
      cyc(1'b0, addr, 8'h00);
      data = rdata;
      idle();
   endtask : reg_rd

   task automatic reg_wr(input logic [2:0] addr, input logic [7:0] data);
      cyc(1'b1, addr, data);
      idle();
   endtask : reg_wr

   // counts cycles while the chosen output (0 pull, 1 irq) holds lvl
   task automatic span(input int sel, input logic lvl, output int cnt);
      cnt = 0;
      while (((sel == 0) ? dq_oe : irq) === lvl && cnt < 30000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : span

   task automatic bus_reset(output int cnt);
      reg_wr(3'h0, 8'h01);
      span(0, 1'b0, cnt);
      span(0, 1'b1, cnt);
      check("reset low ticks", 16'((cnt + TD / 2) / TD), 16'd500);
      span(1, 1'b0, cnt);
      check("release to done ticks", 16'((cnt + TD / 2) / TD), 16'd500);
   endtask : bus_reset

   initial begin
      #(90_000 * 40);
      err_count++;
      $display("watchdog expired");
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1 rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      for (int i = 0; i < 8; i++) begin
         if (ROWS[i].wr) reg_wr(ROWS[i].addr, ROWS[i].data);
         reg_rd(ROWS[i].addr, v);
         check("row read", {8'h00, v}, {8'h00, ROWS[i].exp});
         check("row irq", {15'h0, irq}, {15'h0, ROWS[i].irq});
         $display("row %0d done", i);
      end
      present = 1'b1;
      reg_wr(3'h3, 8'h03);
      bus_reset(n);
      reg_rd(3'h2, v);
      check("flags answered", {8'h00, v}, 16'h0001);
      check("irq after read", {15'h0, irq}, 16'h0000);
      reg_rd(3'h0, v);
      check("command after reset", {8'h00, v}, 16'h0000);
      $display("answered reset done");
      present = 1'b0;
      bus_reset(n);
      reg_rd(3'h2, v);
      check("flags unanswered", {8'h00, v}, 16'h0003);
      $display("unanswered reset done");
      mask = 8'h41;
      reg_wr(3'h3, 8'h12);
      reg_wr(3'h1, 8'hf3);
      span(1, 1'b0, n);
      cyc(1'b0, 3'h2, 8'h00);
      check("flags after byte", {8'h00, rdata}, 16'h001c);
      cyc(1'b0, 3'h2, 8'h00);
      check("flags reread", {8'h00, rdata}, 16'h0010);
      idle();
      reg_rd(3'h1, v);
      check("received byte", {8'h00, v}, 16'h00b2);
      check("slave saw byte", {8'h00, cap}, 16'h00b2);
      reg_rd(3'h2, v);
      check("flags after rx read", {8'h00, v}, 16'h0000);
      $display("byte done");
      mask = 8'h00;
      n = 0;
      while (tx_ready === 1'b1 && n < 12) begin
         cyc(1'b1, 3'h1, 8'h55);
         n++;
      end
      idle();
      check("bytes taken", 16'(n), 16'd9);
      check("tx ready full", {15'h0, tx_ready}, 16'h0000);
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("oe in reset", {15'h0, dq_oe}, 16'h0000);
      check("irq in reset", {15'h0, irq}, 16'h0001);
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("tx ready after reset", {15'h0, tx_ready}, 16'h0001);
      reg_rd(3'h2, v);
      check("flags after reset", {8'h00, v}, 16'h000e);
      reg_rd(3'h3, v);
      check("enable after reset", {8'h00, v}, 16'h0000);
      $display("fill and reset done");
      stop_test();
   end
endmodule : swl_master_test
